// ---- smb_regs.svh ----
// Constants shared by both ends of the SMBus configuration port
`ifndef SMB_REGS_SVH
`define SMB_REGS_SVH

// Slave address of strap value zero, and strap default
`define SMB_ADDR_BASE 7'h58
`define SMB_STRAP_DEFAULT 4'h0

// Direction bit and acknowledge levels
`define SMB_RW_WRITE 1'b0
`define SMB_RW_READ 1'b1
`define SMB_NACK 1'b1

// Timing figures in ns and derived mclk counts
`define SMB_MCLK_PERIOD_NS 8
`define SMB_BUS_FREE_TIME_NS 4700
`define SMB_CLOCK_HIGH_TIME_MAX_NS 50000
`define SMB_SCL_QUARTER_NS 2500
`define SMB_BUS_FREE_CYC ((`SMB_BUS_FREE_TIME_NS + \
    `SMB_MCLK_PERIOD_NS - 1) / `SMB_MCLK_PERIOD_NS)
`define SMB_CLOCK_HIGH_MAX_CYC ((`SMB_CLOCK_HIGH_TIME_MAX_NS + \
    `SMB_MCLK_PERIOD_NS - 1) / `SMB_MCLK_PERIOD_NS)
`define SMB_SCL_QUARTER_CYC (`SMB_SCL_QUARTER_NS / `SMB_MCLK_PERIOD_NS)

`endif

// ---- smb_pkg.sv ----
// Types shared by both ends of the SMBus configuration port
package smb_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [6:0] slave_addr_t;
    typedef logic [3:0] strap_t;
    // Device byte engine states
    typedef enum logic [2:0] {D_ADDR, D_REG, D_DATA, D_TXD, D_WAIT} dev_state_e;
    // Host bus symbols
    typedef enum logic [2:0] {
        OP_IDLE, OP_CLR, OP_S, OP_SR, OP_TX, OP_RX, OP_P
    } host_op_e;
endpackage

// ---- smb_if.sv ----
// Two-wire link between the SMBus host and the device
`timescale 1ns/1ns
interface smb_if;
    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic scl;
    logic sda;

    // Open-drain wires with pull-ups
    assign scl = ~(host_scl_oe & ~host_scl_o);
    assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

    modport host (
        output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe,
        input scl, sda
    );
    modport dev (
        output dev_sda_o, dev_sda_oe,
        input scl, sda
    );
endinterface

// ---- smb_dev.sv ----
// SMBus slave port giving byte access to configuration registers
//
// Overview of operation
// - Respond only when enable strap is high
// - Address is 58h plus four strap bits
// - Floating straps read zero, address byte B0h
// - Address byte ends with direction bit, zero writes
// - Sixteen selectable addresses, one per strap
// - SDA stable while SCL high
// - SDA falling, SCL high means START
// - SDA rising, SCL high means STOP
// - Idle after bus free or high timeout
// - START, address, write bit, device acks
// - Register address byte, device acks
// - Write data byte acked, host stops
// - Repeated START, read address, device acks
// - Device shifts out selected register byte
// - Host NACKs read byte, then STOP
`timescale 1ns/1ns
`include "smb_regs.svh"

module smb_dev #(
    parameter int BUS_FREE_CYC = `SMB_BUS_FREE_CYC,
    parameter int CLOCK_HIGH_MAX_CYC = `SMB_CLOCK_HIGH_MAX_CYC
) (
    input wire logic mclk_i,                 // System clock
    input wire logic rst_b_i,                // Synchronous reset, low
    smb_if.dev link,                         // SMBus pins
    input wire smb_pkg::strap_t addr_strap_i, // Address straps
    input wire logic serial_mgmt_enable_strap_i, // Slave enable strap
    output logic wr_en_o,                    // Register write pulse
    output smb_pkg::byte_t wr_addr_o,        // Write register address
    output smb_pkg::byte_t wr_data_o,        // Write data
    output logic rd_en_o,                    // Register read pulse
    output smb_pkg::byte_t rd_addr_o,        // Read register address
    input wire smb_pkg::byte_t rd_data_i,    // Read data, with rd_en_o
    output logic bus_idle_o                  // Bus idle level
);
    import smb_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic strap_s1_reg;
    logic strap_s2_reg;
    strap_t ad_s1_reg;
    strap_t ad_s2_reg;
    logic strap_done_reg;
    logic enable_reg;
    slave_addr_t dev_addr_reg;
    logic scl_s1_reg, scl_s2_reg, scl_d_reg;
    logic sda_s1_reg, sda_s2_reg, sda_d_reg;
    logic start_m, stop_m;
    logic stop_seen_reg;
    logic armed_reg;
    logic link_ok_reg;
    logic [15:0] idle_cnt_reg;
    logic bus_idle_reg;
    logic drv_s1_reg, drv_s2_reg;
    logic sda_oe_reg;
    logic wt_s1_reg, wt_s2_reg, wt_d_reg;
    logic rt_s1_reg, rt_s2_reg, rt_d_reg;
    logic wr_en_reg, rd_en_reg;
    byte_t wr_addr_reg, wr_data_reg, rd_addr_reg;
    byte_t rd_hold_reg;
    // Link domain
    logic sda_rise_reg;
    dev_state_e dstate_reg;
    logic [3:0] bit_cnt_reg;
    byte_t shift_reg;
    byte_t tx_reg;
    logic drive_reg;
    byte_t reg_addr_reg;
    byte_t wdata_reg;
    // Toggles start known; the link engine has no reset of its own
    logic reg_tgl_reg = 1'b0;
    logic wr_tgl_reg = 1'b0;
    logic start_det;
    byte_t rx_byte;

    // Address match against the strapped address
    function automatic logic addr_hit(input byte_t b);
        return enable_reg & (b[7:1] == dev_addr_reg);
    endfunction

    // ------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------

    // Two-stage synchronisers for the strap pins
    always_ff @(posedge mclk_i) begin
        strap_s1_reg <= serial_mgmt_enable_strap_i;
        strap_s2_reg <= strap_s1_reg;
        ad_s1_reg <= addr_strap_i;
        ad_s2_reg <= ad_s1_reg;
    end

    // Straps are taken once after reset release
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            strap_done_reg <= 1'b0;
            enable_reg <= 1'b0;
            dev_addr_reg <= `SMB_ADDR_BASE + {3'h0, `SMB_STRAP_DEFAULT};
        end else if (!strap_done_reg) begin
            strap_done_reg <= 1'b1;
            enable_reg <= strap_s2_reg;
            dev_addr_reg <= `SMB_ADDR_BASE + {3'h0, ad_s2_reg};
        end
    end

    // ------------------------------------------------------------
    // Bus condition watch on the system clock
    // ------------------------------------------------------------

    // Synchronise the wires and keep one older sample
    always_ff @(posedge mclk_i) begin
        scl_s1_reg <= link.scl;
        scl_s2_reg <= scl_s1_reg;
        scl_d_reg <= scl_s2_reg;
        sda_s1_reg <= link.sda;
        sda_s2_reg <= sda_s1_reg;
        sda_d_reg <= sda_s2_reg;
    end

    assign start_m = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
    assign stop_m = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;

    // Stop history and high-time counter
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            stop_seen_reg <= 1'b0;
            idle_cnt_reg <= 16'h0000;
        end else begin
            if (stop_m) begin
                stop_seen_reg <= 1'b1;
            end else if (start_m) begin
                stop_seen_reg <= 1'b0;
            end
            if (!(scl_s2_reg & sda_s2_reg)) begin
                idle_cnt_reg <= 16'h0000;
            end else if (idle_cnt_reg != 16'hFFFF) begin
                idle_cnt_reg <= idle_cnt_reg + 16'h0001;
            end
        end
    end

    // Idle once both lines stay high long enough
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            bus_idle_reg <= 1'b0;
        end else if (!(scl_s2_reg & sda_s2_reg)) begin
            bus_idle_reg <= 1'b0;
        end else if ((stop_seen_reg && idle_cnt_reg >= 16'(BUS_FREE_CYC))
                || idle_cnt_reg >= 16'(CLOCK_HIGH_MAX_CYC)) begin
            bus_idle_reg <= 1'b1;
        end
    end

    // Link engine is trusted after its first clock following a START
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            armed_reg <= 1'b0;
            link_ok_reg <= 1'b0;
        end else begin
            if (start_m) begin
                armed_reg <= 1'b1;
            end
            if (armed_reg && scl_d_reg && !scl_s2_reg) begin
                link_ok_reg <= 1'b1;
            end
        end
    end

    // SDA pull-down, retimed onto the system clock
    always_ff @(posedge mclk_i) begin
        drv_s1_reg <= drive_reg;
        drv_s2_reg <= drv_s1_reg;
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            sda_oe_reg <= 1'b0;
        end else begin
            sda_oe_reg <= link_ok_reg & enable_reg & drv_s2_reg & ~stop_m;
        end
    end

    // ------------------------------------------------------------
    // Register side handshake
    // ------------------------------------------------------------

    // Toggle synchronisers for write and address events; they follow the
    // toggles through reset, so an old toggle gives no pulse after release
    always_ff @(posedge mclk_i) begin
        wt_s1_reg <= wr_tgl_reg;
        wt_s2_reg <= wt_s1_reg;
        wt_d_reg <= wt_s2_reg;
        rt_s1_reg <= reg_tgl_reg;
        rt_s2_reg <= rt_s1_reg;
        rt_d_reg <= rt_s2_reg;
    end

    // Write and read strobes with stable address and data
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            wr_en_reg <= 1'b0;
            rd_en_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            wr_data_reg <= 8'h00;
            rd_addr_reg <= 8'h00;
        end else begin
            wr_en_reg <= enable_reg & (wt_s2_reg ^ wt_d_reg);
            rd_en_reg <= enable_reg & (rt_s2_reg ^ rt_d_reg);
            if (wt_s2_reg ^ wt_d_reg) begin
                wr_addr_reg <= reg_addr_reg;
                wr_data_reg <= wdata_reg;
            end
            if (rt_s2_reg ^ rt_d_reg) begin
                rd_addr_reg <= reg_addr_reg;
            end
        end
    end

    // Read data held for the link engine
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            rd_hold_reg <= 8'h00;
        end else if (rd_en_reg) begin
            rd_hold_reg <= rd_data_i;
        end
    end

    // ------------------------------------------------------------
    // Link engine on SCL
    // ------------------------------------------------------------

    // Data bit taken while SCL is high
    always_ff @(posedge link.scl) begin
        sda_rise_reg <= link.sda;
    end

    // SDA low at the fall after a high rise sample, or outside a byte
    assign start_det = ~link.sda
        & (sda_rise_reg | (dstate_reg == D_WAIT));
    assign rx_byte = {shift_reg[6:0], sda_rise_reg};

    // Byte engine; every step happens at an SCL fall
    always_ff @(negedge link.scl) begin
        if (start_det) begin
            dstate_reg <= D_ADDR;
            bit_cnt_reg <= 4'h0;
            drive_reg <= 1'b0;
        end else begin
            case (dstate_reg)
                D_ADDR, D_REG, D_DATA: begin
                    if (bit_cnt_reg != 4'h8) begin
                        shift_reg <= rx_byte;
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        if (bit_cnt_reg == 4'h7) begin
                            drive_reg <= (dstate_reg != D_ADDR)
                                | addr_hit(rx_byte);
                        end
                        if (bit_cnt_reg == 4'h7 && dstate_reg == D_REG) begin
                            reg_addr_reg <= rx_byte;
                            reg_tgl_reg <= ~reg_tgl_reg;
                        end
                        if (bit_cnt_reg == 4'h7 && dstate_reg == D_DATA) begin
                            wdata_reg <= rx_byte;
                            wr_tgl_reg <= ~wr_tgl_reg;
                        end
                    end else begin
                        bit_cnt_reg <= 4'h0;
                        drive_reg <= 1'b0;
                        if (dstate_reg == D_ADDR && !drive_reg) begin
                            dstate_reg <= D_WAIT;
                        end else if (dstate_reg == D_ADDR
                                && shift_reg[0] == `SMB_RW_READ) begin
                            dstate_reg <= D_TXD;
                            tx_reg <= {rd_hold_reg[6:0], 1'b0};
                            drive_reg <= ~rd_hold_reg[7];
                            bit_cnt_reg <= 4'h1;
                        end else if (dstate_reg == D_ADDR) begin
                            dstate_reg <= D_REG;
                        end else if (dstate_reg == D_REG) begin
                            dstate_reg <= D_DATA;
                        end else begin
                            dstate_reg <= D_WAIT;
                        end
                    end
                end
                D_TXD: begin
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    if (bit_cnt_reg < 4'h8) begin
                        drive_reg <= ~tx_reg[7];
                        tx_reg <= {tx_reg[6:0], 1'b0};
                    end else if (bit_cnt_reg == 4'h8) begin
                        drive_reg <= 1'b0;
                    end else begin
                        dstate_reg <= D_WAIT;
                    end
                end
                default: begin
                    dstate_reg <= D_WAIT;
                    drive_reg <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign link.dev_sda_oe = sda_oe_reg;
    assign link.dev_sda_o = 1'b0;
    assign wr_en_o = wr_en_reg;
    assign wr_addr_o = wr_addr_reg;
    assign wr_data_o = wr_data_reg;
    assign rd_en_o = rd_en_reg;
    assign rd_addr_o = rd_addr_reg;
    assign bus_idle_o = bus_idle_reg;
endmodule

// ---- smb_host.sv ----
// SMBus host issuing single-byte register writes and reads
`timescale 1ns/1ns
`include "smb_regs.svh"

module smb_host #(
    parameter int QUARTER_CYC = `SMB_SCL_QUARTER_CYC
) (
    input wire logic mclk_i,                // System clock
    input wire logic rst_b_i,               // Synchronous reset, low
    smb_if.host link,                       // SMBus pins
    input wire logic cmd_valid_i,           // Command request
    input wire logic cmd_read_i,            // 1 read, 0 write
    input wire smb_pkg::slave_addr_t cmd_dev_i, // Slave address
    input wire smb_pkg::byte_t cmd_reg_i,   // Register address
    input wire smb_pkg::byte_t cmd_wdata_i, // Write data
    output logic cmd_ready_o,               // Ready for a command
    output logic done_o,                    // Command finished pulse
    output logic nack_o,                    // Last command refused
    output smb_pkg::byte_t rdata_o          // Last read data
);
    import smb_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic sda_s1_reg, sda_s2_reg;
    host_op_e op_reg;
    logic [1:0] ph_reg;
    logic [15:0] tick_reg;
    logic [2:0] step_reg;
    logic [3:0] bit_cnt_reg;
    logic [8:0] tx_reg;
    logic [8:0] rx_reg;
    logic rd_reg;
    slave_addr_t dev_reg;
    byte_t reg_reg, wdata_reg;
    logic scl_oe_reg, sda_oe_reg;
    logic ready_reg, done_reg, nack_reg;
    byte_t rdata_reg;
    host_op_e nop;
    logic [1:0] pins;

    // Symbol at each step of a transfer
    function automatic host_op_e seq_op(input logic [2:0] s, input logic r);
        case (s)
            3'h0: return OP_S;
            3'h1, 3'h2: return OP_TX;
            3'h3: return r ? OP_SR : OP_TX;
            3'h4: return r ? OP_TX : OP_P;
            3'h5: return OP_RX;
            default: return OP_P;
        endcase
    endfunction

    // Byte sent at a transmit step
    function automatic byte_t seq_byte(input logic [2:0] s);
        case (s)
            3'h1: return {dev_reg, `SMB_RW_WRITE};
            3'h2: return reg_reg;
            3'h3: return wdata_reg;
            default: return {dev_reg, `SMB_RW_READ};
        endcase
    endfunction

    // Pulls {scl, sda} for a symbol phase; b is the bit to send
    function automatic logic [1:0] drive(input host_op_e o,
            input logic [1:0] p, input logic b);
        case (o)
            OP_CLR: return {p == 2'h0, 1'b0};
            OP_S: return {p == 2'h3, p[1]};
            OP_SR: return {p == 2'h0 || p == 2'h3, p[1]};
            OP_TX, OP_RX: return {p == 2'h0 || p == 2'h3, ~b};
            OP_P: return {p == 2'h0, ~p[1]};
            default: return 2'h0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Symbol engine
    // ------------------------------------------------------------

    // Synchroniser for the returning data wire
    always_ff @(posedge mclk_i) begin
        sda_s1_reg <= link.sda;
        sda_s2_reg <= sda_s1_reg;
    end

    // Next symbol after the current one ends
    always_comb begin
        nop = seq_op(step_reg + 3'h1, rd_reg);
        if (op_reg == OP_TX && rx_reg[0] == `SMB_NACK) begin
            nop = OP_P;
        end
        pins = drive(nop, 2'h0, nop == OP_TX
            ? seq_byte(step_reg + 3'h1) == 8'h00 ? 1'b0 : 1'b1 : 1'b1);
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            op_reg <= OP_CLR;
            ph_reg <= 2'h0;
            tick_reg <= 16'h0000;
            step_reg <= 3'h0;
            bit_cnt_reg <= 4'h0;
            tx_reg <= 9'h1FF;
            rx_reg <= 9'h1FF;
            scl_oe_reg <= 1'b1;
            sda_oe_reg <= 1'b0;
            ready_reg <= 1'b0;
            done_reg <= 1'b0;
            nack_reg <= 1'b0;
            rdata_reg <= 8'h00;
            rd_reg <= 1'b0;
            dev_reg <= 7'h00;
            reg_reg <= 8'h00;
            wdata_reg <= 8'h00;
        end else begin
            done_reg <= 1'b0;
            if (op_reg == OP_IDLE) begin
                if (cmd_valid_i && ready_reg) begin
                    op_reg <= OP_S;
                    ph_reg <= 2'h0;
                    tick_reg <= 16'h0000;
                    step_reg <= 3'h0;
                    ready_reg <= 1'b0;
                    nack_reg <= 1'b0;
                    rd_reg <= cmd_read_i;
                    dev_reg <= cmd_dev_i;
                    reg_reg <= cmd_reg_i;
                    wdata_reg <= cmd_wdata_i;
                end
            end else if (tick_reg != 16'(QUARTER_CYC - 1)) begin
                tick_reg <= tick_reg + 16'h0001;
            end else begin
                tick_reg <= 16'h0000;
                if (ph_reg == 2'h2 && (op_reg == OP_TX || op_reg == OP_RX)) begin
                    rx_reg <= {rx_reg[7:0], sda_s2_reg};
                end
                if (ph_reg != 2'h3) begin
                    ph_reg <= ph_reg + 2'h1;
                    {scl_oe_reg, sda_oe_reg} <=
                        drive(op_reg, ph_reg + 2'h1, tx_reg[8]);
                end else if ((op_reg == OP_TX || op_reg == OP_RX)
                        && bit_cnt_reg != 4'h8) begin
                    ph_reg <= 2'h0;
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    tx_reg <= {tx_reg[7:0], 1'b1};
                    {scl_oe_reg, sda_oe_reg} <= drive(op_reg, 2'h0, tx_reg[7]);
                end else if (op_reg == OP_P || op_reg == OP_CLR) begin
                    op_reg <= OP_IDLE;
                    ready_reg <= 1'b1;
                    done_reg <= (op_reg == OP_P);
                end else begin
                    ph_reg <= 2'h0;
                    bit_cnt_reg <= 4'h0;
                    op_reg <= nop;
                    if (nop == OP_P && op_reg == OP_TX) begin
                        nack_reg <= rx_reg[0];
                    end
                    if (op_reg == OP_RX) begin
                        rdata_reg <= rx_reg[8:1];
                    end
                    step_reg <= step_reg + 3'h1;
                    tx_reg <= nop == OP_TX
                        ? {seq_byte(step_reg + 3'h1), 1'b1} : 9'h1FF;
                    {scl_oe_reg, sda_oe_reg} <= {pins[1],
                        nop == OP_TX ? ~seq_byte(step_reg + 3'h1)
                        [7] : pins[0]};
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign link.host_scl_oe = scl_oe_reg;
    assign link.host_scl_o = 1'b0;
    assign link.host_sda_oe = sda_oe_reg;
    assign link.host_sda_o = 1'b0;
    assign cmd_ready_o = ready_reg;
    assign done_o = done_reg;
    assign nack_o = nack_reg;
    assign rdata_o = rdata_reg;
endmodule

// ---- smb_link_chk.sv ----
// Assertions on the SMBus link between host and device
`timescale 1ns/1ns
`include "smb_regs.svh"
module smb_link_chk #(
    parameter int CLOCK_HIGH_MAX_CYC = `SMB_CLOCK_HIGH_MAX_CYC
) (
    input wire logic mclk_i,     // System clock
    input wire logic rst_b_i,    // Reset, low
    input wire logic scl,        // Clock wire
    input wire logic sda,        // Data wire
    input wire logic dev_sda_oe, // Device pulls data
    input wire logic wr_en_o,    // Write pulse
    input wire logic rd_en_o,    // Read pulse
    input wire logic bus_idle_o  // Idle level
);
    int hi_cnt;
    // Cycles with both wires high
    always_ff @(posedge mclk_i) begin
        hi_cnt <= (scl && sda) ? hi_cnt + 1 : 0;
    end
    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (!rst_b_i);
    sequence start_s;
        scl && $fell(sda);
    endsequence
    sequence stop_s;
        scl && $rose(sda);
    endsequence
    dev_stable_a: assert property (
        scl && $past(scl) |-> $stable(dev_sda_oe))
        else $error("device data changed while clock high");
    edge_low_a: assert property (
        $changed(dev_sda_oe) |-> !scl [*3])
        else $error("device data changed near clock high");
    start_quiet_a: assert property (
        start_s |-> !dev_sda_oe)
        else $error("device pulls data at start");
    stop_quiet_a: assert property (
        stop_s |=> !dev_sda_oe [*2])
        else $error("device pulls data after stop");
    idle_set_a: assert property (
        hi_cnt > CLOCK_HIGH_MAX_CYC + 4 |-> bus_idle_o)
        else $error("bus idle not flagged");
    busy_low_a: assert property (
        !scl [*4] |-> !bus_idle_o)
        else $error("bus idle while clock low");
    wr_pulse_a: assert property (
        wr_en_o |-> !scl ##1 !wr_en_o)
        else $error("write strobe misplaced");
    rd_pulse_a: assert property (
        rd_en_o |-> !scl ##1 !rd_en_o)
        else $error("read strobe misplaced");
endmodule

// ---- smbus_slave_config_port_test.sv ----
// Bench joining SMBus host and device ends
`timescale 1ns/1ns
module smbus_slave_config_port_test;
    import smb_pkg::*;
    logic mclk_i = 0;
    logic rst_b_i = 0;
    logic cmd_valid_i = 0;
    logic cmd_read_i = 0;
    slave_addr_t cmd_dev_i = 7'h00;
    byte_t cmd_reg_i = 8'h00;
    byte_t cmd_wdata_i = 8'h00;
    strap_t strap = 4'h0;
    logic en_strap = 1;
    logic cmd_ready_o, done_o, nack_o, wr_en_o, rd_en_o, bus_idle_o;
    byte_t rdata_o, wr_addr_o, wr_data_o, rd_addr_o, rd_data_i;
    byte_t regs [256];
    int n_fail = 0;
    int checked = 0;
    int n_wr = 0;
    int w;
    smb_if link ();
    smb_host #(.QUARTER_CYC(4)) u_smb_host (.mclk_i, .rst_b_i, .link(link),
        .cmd_valid_i, .cmd_read_i, .cmd_dev_i, .cmd_reg_i, .cmd_wdata_i,
        .cmd_ready_o, .done_o, .nack_o, .rdata_o);
    smb_dev #(.BUS_FREE_CYC(20), .CLOCK_HIGH_MAX_CYC(40)) u_smb_dev (
        .mclk_i, .rst_b_i, .link(link), .addr_strap_i(strap),
        .serial_mgmt_enable_strap_i(en_strap), .wr_en_o, .wr_addr_o,
        .wr_data_o, .rd_en_o, .rd_addr_o, .rd_data_i, .bus_idle_o);
    smb_link_chk #(.CLOCK_HIGH_MAX_CYC(40)) u_smb_link_chk (.mclk_i,
        .rst_b_i, .scl(link.scl), .sda(link.sda),
        .dev_sda_oe(link.dev_sda_oe), .wr_en_o, .rd_en_o, .bus_idle_o);
    // Clock of 8 ns
    initial begin
        forever #4 mclk_i = ~mclk_i;
    end
    // Register file behind the device
    assign rd_data_i = regs[rd_addr_o];
    always @(posedge mclk_i) begin
        if (wr_en_o === 1'b1) begin
            regs[wr_addr_o] <= wr_data_o;
            n_wr++;
        end
    end
    task automatic chk(input byte_t seen, input byte_t exp, input string s);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task automatic tick();
        @(posedge mclk_i);
        #1;
    endtask
    task automatic reboot(input logic en, input strap_t s);
        rst_b_i = 0;
        en_strap = en;
        strap = s;
        repeat (6) tick();
        rst_b_i = 1;
    endtask
    task automatic cmd(input logic r, input slave_addr_t d,
            input byte_t a, input byte_t wd);
        int n;
        n = 0;
        while (cmd_ready_o !== 1'b1 && n < 200) begin
            tick();
            n++;
        end
        {cmd_read_i, cmd_dev_i, cmd_reg_i, cmd_wdata_i} = {r, d, a, wd};
        cmd_valid_i = 1;
        tick();
        cmd_valid_i = 0;
        while (done_o !== 1'b1 && n < 2000) begin
            tick();
            n++;
        end
        chk(done_o, 8'h01, "done");
    endtask
    task automatic results();
        if (n_fail == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Cut a hang short
    initial begin
        #400000;
        n_fail++;
        results();
    end
    // Test sequence
    initial begin
        reboot(1, 4'h0);
        cmd(0, 7'h58, 8'h10, 8'hA5);
        chk(nack_o, 8'h00, "write ack");
        chk(regs[8'h10], 8'hA5, "write data");
        cmd(0, 7'h58, 8'hFF, 8'hC3);
        cmd(1, 7'h58, 8'h10, 8'h00);
        chk(nack_o, 8'h00, "read ack");
        chk(rdata_o, 8'hA5, "read data");
        cmd(1, 7'h58, 8'hFF, 8'h00);
        chk(rdata_o, 8'hC3, "read top reg");
        w = n_wr;
        cmd(0, 7'h59, 8'h10, 8'h00);
        chk(nack_o, 8'h01, "other address");
        chk(8'(n_wr), 8'(w), "no write");
        repeat (60) tick();
        chk(bus_idle_o, 8'h01, "idle");
        reboot(0, 4'h0);
        cmd(0, 7'h58, 8'h20, 8'h11);
        chk(nack_o, 8'h01, "disabled");
        for (int s = 0; s < 16; s++) begin
            reboot(1, strap_t'(s));
            cmd(0, slave_addr_t'(7'h58 + s), 8'(s), 8'(s) ^ 8'h5A);
            chk(nack_o, 8'h00, "strap ack");
            chk(regs[s], 8'(s) ^ 8'h5A, "strap data");
            cmd(0, slave_addr_t'(7'h58 + ((s + 1) % 16)), 8'h00, 8'h00);
            chk(nack_o, 8'h01, "strap other");
        end
        results();
    end
endmodule
